/* design/usw_cfg.svh */
// Purpose: constants for the suspend and remote wakeup controller
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef USW_CFG_SVH
`define USW_CFG_SVH
`define USW_GPIO_W     8
`define USW_SEL_W      2
`define USW_SEL_LIGHT  2'h0
`define USW_SEL_LINK   2'h1
`define USW_SEL_DEEP   2'h2
`define USW_SEL_RESET  2'h2
`define USW_SEL_SPARE  2'h3
// wake enable field positions
`define USW_EN_FRAME   0
`define USW_EN_DIRECT  1
`define USW_EN_LINK    2
`define USW_EN_W       3
`define USW_EN_RESET   3'h0
`endif

/* design/usw_pkg.sv */
// Purpose: types for the suspend and remote wakeup controller
// Assumes: nothing
// Notes:   states of the suspend sequencer
`default_nettype none
package usw_pkg;
  typedef enum logic [1:0] {
    USW_AWAKE,
    USW_SUSPENDED,
    USW_WAKING
  } usw_state_e;
  typedef logic [1:0] usw_sel_t;
endpackage : usw_pkg
`default_nettype wire

/* design/usw_edge.sv */
// Purpose: rising edge detector for the wake inputs
// Assumes: inputs synchronous to mclk
// Notes:   output is a registered one-cycle pulse per bit
`default_nettype none
module usw_edge #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // levels in, pulses out
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] prev;  // last sampled level

  // two flops per bit (prev and rise), generated
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        prev[i] <= 1'b0;
        rise[i] <= 1'b0;
      end else begin
        prev[i] <= level[i];
        rise[i] <= level[i] & ~prev[i];
      end
    end
  end
endmodule : usw_edge
`default_nettype wire

/* design/usw_suspend_ctrl.sv */
// Purpose: suspend variant selection and remote wakeup request
// Assumes: all inputs synchronous to mclk
// Notes:   wakeReq stands until the host resumes the bus
//
// Operation
// - light variant accepts pins, frames, directed frames
// - light variant stops module clocks, frames wake
// - link variant wakes on pins, link change
// - deep variant pins only, default after reset
// - each network wake source individually enabled
// - all eight pins usable as wake
`include "usw_cfg.svh"
`default_nettype none
module usw_suspend_ctrl
  import usw_pkg::*;
(
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // software configuration
  input  wire usw_pkg::usw_sel_t        suspendSel,
  input  wire logic [`USW_EN_W-1:0]     wakeEnable,
  input  wire logic [`USW_GPIO_W-1:0]   gpioWakeEnable,
  // usb bus state from the upstream port
  input  wire logic                     usbSuspend,
  // wake sources
  input  wire logic [`USW_GPIO_W-1:0]   gpioIn,
  input  wire logic                     wakeFrame,
  input  wire logic                     directFrame,
  input  wire logic                     linkChange,
  // outputs
  output logic                          wakeReq,
  output logic                          macClkStop,
  output logic                          linkMonOn,
  output logic                          frameDetOn,
  output usw_pkg::usw_sel_t             activeSel
);
  import usw_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // declarations
  usw_state_e                state;       // sequencer state
  usw_state_e                next_state;  // next sequencer state
  logic [`USW_EN_W-1:0]      enLatched;   // enables caught at entry
  logic [`USW_GPIO_W-1:0]    gpioEnLatched; // pin enables caught at entry
  logic [`USW_GPIO_W-1:0]    gpioRise;    // pin rising edges
  logic                      suspPrev;    // last usbSuspend
  logic                      enter;       // suspend entry pulse
  logic                      wakeHit;     // qualified wake event

  // decode whether a variant admits frame-based wake
  function automatic logic usw_frames_ok(input usw_sel_t s);
    return s == `USW_SEL_LIGHT;
  endfunction : usw_frames_ok

  // decode whether a variant admits link change wake
  function automatic logic usw_link_ok(input usw_sel_t s);
    return s == `USW_SEL_LINK;
  endfunction : usw_link_ok

  //////////////////////////////////////////////////////////////////////
  // pin edge detection
  usw_edge #(.W(`USW_GPIO_W)) u_edge (
    .mclk  (mclk),
    .rstn  (rstn),
    .level (gpioIn),
    .rise  (gpioRise)
  );

  //////////////////////////////////////////////////////////////////////
  // suspend entry detection
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      suspPrev <= 1'b0;
    end else begin
      suspPrev <= usbSuspend;
    end
  end
  // only a rising edge while awake enters, so a bus held suspended cannot re-enter
  assign enter = usbSuspend & ~suspPrev & (state == USW_AWAKE);

  //////////////////////////////////////////////////////////////////////
  // configuration capture
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      activeSel     <= `USW_SEL_RESET;
      enLatched     <= `USW_EN_RESET;
      gpioEnLatched <= '0;
    end else if (enter) begin
      activeSel     <= suspendSel;
      enLatched     <= wakeEnable;
      gpioEnLatched <= gpioWakeEnable;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // wake qualification
  // pins count on a rising edge only, so a pin held high cannot wake twice
  always_comb begin
    wakeHit = |(gpioRise & gpioEnLatched);
    // frame sources only in light variant
    if (usw_frames_ok(activeSel)) begin
      wakeHit = wakeHit | (wakeFrame & enLatched[`USW_EN_FRAME])
                        | (directFrame & enLatched[`USW_EN_DIRECT]);
    end
    // link change only in link variant
    if (usw_link_ok(activeSel)) begin
      wakeHit = wakeHit | (linkChange & enLatched[`USW_EN_LINK]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      USW_AWAKE: begin
        if (enter) begin
          next_state = USW_SUSPENDED;
        end
      end
      USW_SUSPENDED: begin
        if (!usbSuspend) begin
          next_state = USW_AWAKE;     // host resumed first
        end else if (wakeHit) begin
          next_state = USW_WAKING;
        end
      end
      USW_WAKING: begin
        if (!usbSuspend) begin
          next_state = USW_AWAKE;
        end
      end
      default: begin
        next_state = USW_AWAKE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= USW_AWAKE;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs, all registered
  // outputs follow next_state so they line up with the state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wakeReq    <= 1'b0;
      macClkStop <= 1'b0;
      linkMonOn  <= 1'b1;
      frameDetOn <= 1'b1;
    end else begin
      wakeReq    <= (next_state == USW_WAKING);
      // clocks stopped in every suspended state
      macClkStop <= (next_state != USW_AWAKE);
      // frame detector kept alive only in light variant
      frameDetOn <= (next_state == USW_AWAKE) |
                    usw_frames_ok(enter ? suspendSel : activeSel);
      // link monitor kept alive in link variant
      linkMonOn  <= (next_state == USW_AWAKE) |
                    usw_link_ok(enter ? suspendSel : activeSel);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertions
  a_deep_pins_only: assert property (@(posedge mclk) disable iff (!rstn)
    (state == USW_SUSPENDED && activeSel == `USW_SEL_DEEP && usbSuspend && !(|(gpioRise & gpioEnLatched)))
      |=> !wakeReq) else $error("deep variant woke without a pin");
  a_frame_wake: assert property (@(posedge mclk) disable iff (!rstn)
    (state == USW_SUSPENDED && usbSuspend && activeSel == `USW_SEL_LIGHT && wakeFrame && enLatched[`USW_EN_FRAME])
      |=> wakeReq) else $error("frame wake missed in light variant");
  a_direct_wake: assert property (@(posedge mclk) disable iff (!rstn)
    (state == USW_SUSPENDED && usbSuspend && activeSel == `USW_SEL_LIGHT && directFrame && enLatched[`USW_EN_DIRECT])
      |=> wakeReq) else $error("directed frame wake missed");
  a_link_ignores: assert property (@(posedge mclk) disable iff (!rstn)
    (state == USW_SUSPENDED && usbSuspend && activeSel == `USW_SEL_LINK &&
     !(|(gpioRise & gpioEnLatched)) && !linkChange)
      |=> !wakeReq) else $error("link variant woke on frame");
  a_link_wake: assert property (@(posedge mclk) disable iff (!rstn)
    (state == USW_SUSPENDED && usbSuspend && activeSel == `USW_SEL_LINK && linkChange && enLatched[`USW_EN_LINK])
      |=> wakeReq) else $error("link change wake missed");
  a_pin_wake: assert property (@(posedge mclk) disable iff (!rstn)
    (state == USW_SUSPENDED && usbSuspend && |(gpioRise & gpioEnLatched)) |=> wakeReq)
    else $error("pin wake missed");
  a_clk_stop: assert property (@(posedge mclk) disable iff (!rstn)
    (state != USW_AWAKE) |-> macClkStop) else $error("clocks not stopped in suspend");
  a_sample_entry: assert property (@(posedge mclk) disable iff (!rstn)
    enter |=> (activeSel == $past(suspendSel) && enLatched == $past(wakeEnable) &&
               gpioEnLatched == $past(gpioWakeEnable)))
    else $error("configuration not sampled at entry");
  a_sel_stable: assert property (@(posedge mclk) disable iff (!rstn)
    (state == USW_SUSPENDED) |=> $stable(activeSel)) else $error("variant changed while suspended");
  a_entry_stop: assert property (@(posedge mclk) disable iff (!rstn)
    ($rose(usbSuspend) && state == USW_AWAKE) |=> macClkStop)
    else $error("clocks not stopped after suspend entry");
  a_resume_release: assert property (@(posedge mclk) disable iff (!rstn)
    !usbSuspend |=> (!wakeReq && !macClkStop))
    else $error("request or clock stop held after resume");
  a_detector_power: assert property (@(posedge mclk) disable iff (!rstn)
    (state != USW_AWAKE) |-> (frameDetOn == (activeSel == `USW_SEL_LIGHT)))
    else $error("frame detector power wrong in suspend");
  a_link_monitor: assert property (@(posedge mclk) disable iff (!rstn)
    (state != USW_AWAKE) |-> (linkMonOn == (activeSel == `USW_SEL_LINK)))
    else $error("link monitor power wrong in suspend");
  // scenarios worth seeing
  c_light_wake: cover property (@(posedge mclk) state == USW_SUSPENDED && activeSel == `USW_SEL_LIGHT ##1 wakeReq);
  c_link_wake:  cover property (@(posedge mclk) state == USW_SUSPENDED && activeSel == `USW_SEL_LINK ##1 wakeReq);
  c_deep_wake:  cover property (@(posedge mclk) state == USW_SUSPENDED && activeSel == `USW_SEL_DEEP ##1 wakeReq);
  c_host_resume: cover property (@(posedge mclk) state == USW_SUSPENDED ##1 state == USW_AWAKE);
  c_spare_code: cover property (@(posedge mclk) state == USW_SUSPENDED && activeSel == `USW_SEL_SPARE ##1 wakeReq);
endmodule : usw_suspend_ctrl
`default_nettype wire

/* dv/usw_host_model.sv */
// Purpose: upstream host model that suspends and resumes the bus
// Assumes: bench raises suspendCmd to suspend, lowers it to end a trial
// Notes:   resumes resumeDelay cycles after it first sees a wake request
`default_nettype none
module usw_host_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rstn,
  // bench control
  input  wire logic       suspendCmd,
  input  wire logic [3:0] resumeDelay,
  // device side
  input  wire logic       wakeReq,
  output logic            usbSuspend
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] waitCnt;  // cycles of wake request seen
  logic       resumed;  // bus resumed, stays awake until the command drops
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      waitCnt    <= 4'h0;
      resumed    <= 1'b0;
      usbSuspend <= 1'b0;
    end else if (!suspendCmd) begin
      // idle bus, ready for the next suspend
      waitCnt    <= 4'h0;
      resumed    <= 1'b0;
      usbSuspend <= 1'b0;
    end else if (usbSuspend && wakeReq) begin
      // slow or prompt host, as the bench picks
      waitCnt    <= waitCnt + 4'h1;
      resumed    <= (waitCnt == resumeDelay);
      usbSuspend <= (waitCnt != resumeDelay);
    end else begin
      usbSuspend <= !resumed;
    end
  end
endmodule : usw_host_model
`default_nettype wire

/* dv/testbench.sv */
// Purpose: self-checking bench for the suspend and wakeup controller
// Assumes: one note per suspend, compared when the bus resumes
// Notes:   config is scrambled mid-suspend to prove it was captured
`include "usw_cfg.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rstn, suspendCmd, usbSuspend, wakeFrame, directFrame, linkChange;
  logic wakeReq, macClkStop, linkMonOn, frameDetOn, prevSusp, prevMcs, sawWake, entered;
  logic [3:0] resumeDelay;
  logic [2:0] wakeEnable;
  logic [7:0] gpioWakeEnable, gpioIn;
  usw_pkg::usw_sel_t suspendSel, activeSel, capSel;
  logic capF, capL;
  logic [5:0] notes[$];  // {wake, sel, frameDet, linkMon, entered}
  logic [31:0] rngState = 32'h0000_0028;
  int miscompares = 0, samplesChecked = 0, cycles = 0;
  usw_suspend_ctrl usw_suspend_ctrl_inst (.mclk(mclk), .rstn(rstn), .suspendSel(suspendSel),
    .wakeEnable(wakeEnable), .gpioWakeEnable(gpioWakeEnable), .usbSuspend(usbSuspend),
    .gpioIn(gpioIn), .wakeFrame(wakeFrame), .directFrame(directFrame), .linkChange(linkChange),
    .wakeReq(wakeReq), .macClkStop(macClkStop), .linkMonOn(linkMonOn), .frameDetOn(frameDetOn),
    .activeSel(activeSel));
  usw_host_model usw_host_model_inst (.mclk(mclk), .rstn(rstn), .suspendCmd(suspendCmd),
    .resumeDelay(resumeDelay), .wakeReq(wakeReq), .usbSuspend(usbSuspend));
  ////////////////////////////////////////////////////////////////////////
  // xorshift source of random values
  function automatic logic [31:0] xs();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction : xs
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic tally_and_finish();
    if (miscompares == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // one suspend with one wake event of the given kind
  task automatic trial(input int kind);
    logic [1:0] sel;
    logic [2:0] en;
    logic [7:0] gen;
    int bitn;
    logic exp;
    sel = 2'(xs());
    en = 3'(xs());
    gen = 8'(xs());
    bitn = int'(xs() % 8);
    // which sources may wake each variant
    case (kind)
      0: exp = gen[bitn];
      1: exp = (sel == `USW_SEL_LIGHT) && en[`USW_EN_FRAME];
      2: exp = (sel == `USW_SEL_LIGHT) && en[`USW_EN_DIRECT];
      default: exp = (sel == `USW_SEL_LINK) && en[`USW_EN_LINK];
    endcase
    notes.push_back({exp, sel, sel == `USW_SEL_LIGHT, sel == `USW_SEL_LINK, 1'b1});
    @(negedge mclk);
    {suspendSel, wakeEnable, gpioWakeEnable} = {sel, en, gen};
    {wakeFrame, suspendCmd, resumeDelay} = {1'b1, 1'b1, 4'(xs())};
    @(negedge mclk);
    wakeFrame = 1'b0;
    repeat (3) @(negedge mclk);
    // changes after entry must not count
    {suspendSel, wakeEnable, gpioWakeEnable} = {2'(xs() % 3), ~en, ~gen};
    {gpioIn[bitn], wakeFrame, directFrame, linkChange} = 4'b1000 >> kind;
    @(negedge mclk);
    {gpioIn, wakeFrame, directFrame, linkChange} = 11'h000;
    for (int i = 0; i < 30 && usbSuspend; i++) @(negedge mclk);
    suspendCmd = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : trial
  ////////////////////////////////////////////////////////////////////////
  // watcher: capture at entry, compare the oldest note at resume
  always @(posedge mclk) begin
    if (macClkStop && !prevMcs) begin
      {entered, capSel, capF, capL, sawWake} = {1'b1, activeSel, frameDetOn, linkMonOn, 1'b0};
    end
    if (wakeReq) sawWake = 1'b1;
    if (prevSusp && !usbSuspend && notes.size() > 0) begin
      check("suspend", 8'(notes.pop_front()), 8'({sawWake, capSel, capF, capL, entered}));
      entered = 1'b0;
    end
    {prevSusp, prevMcs} = {usbSuspend, macClkStop};
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    {rstn, suspendCmd, resumeDelay, suspendSel, wakeEnable, gpioWakeEnable} = '0;
    {gpioIn, wakeFrame, directFrame, linkChange, prevSusp, prevMcs, entered, sawWake} = '0;
    repeat (20) @(negedge mclk);
    check("reset", 8'h3e, {wakeReq, macClkStop, frameDetOn, linkMonOn, 2'b11, activeSel});
    rstn = 1'b1;
    for (int i = 0; i < 48; i++) trial(i % 4);
    check("notes left", 8'h00, 8'(notes.size()));
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
